// ---- src/period_match_timer8.sv ----
// Period match timer with prescaler, postscaler, match flag interrupt and AHB-Lite slave.
// Summary of operation
// - Timer is clocked by instruction clock, system clock divided by four, via prescaler.
// - Count runs up from zero; on period match it returns to 00h next increment.
// - Each match advances postscaler; postscaler output sets the match event flag.
// - Postscale field bits 6-3 gives one output per N+1 matches.
// - Prescale field bits 1-0: 00 divide 1, 01 divide 4, 1x divide 16.
// - Run bit 2 enables counting when one, stops timer when zero.
// - Count and period registers are fully readable and writable.
// - Reset loads count with 00h and period with FFh.
// - Count write, control write or reset clear prescaler and postscaler.
// - Control write leaves the count value unchanged.
// - Control bit 7 is unimplemented, reads zero, writes ignored.
`timescale 1ns/1ps
module pmt_period_match_timer8 (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt.
  output logic irq
);
  // Bus request and read data.
  pmt_pkg::pmt_req_s req_ff, nxt_req;
  logic [31:0] hrdata_ff, nxt_hrdata;

  // Timing chain.
  logic [1:0] instr_ff, nxt_instr;
  logic [3:0] pre_ff, nxt_pre;
  logic [3:0] post_ff, nxt_post;

  // Software registers.
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] period_ff, nxt_period;
  logic enable_ff, nxt_enable;
  logic flag_ff, nxt_flag;

  // Decoded strobes, ticks and fields.
  logic addrPhase, rdPhase;
  logic wrEn, wrCtrl, wrCount, wrPeriod, wrEnable, wrClear, clearReq, scalerClear;
  logic instrTick, preTick, matchHit, postTick;
  logic runOn;
  logic [1:0] preSel;
  logic [3:0] preLast, postLast;
  logic [7:0] readByte;

  // Read data of the register at an offset.
  function automatic logic [7:0] regRead(input logic [7:0] off, input logic [7:0] c,
                                         input logic [7:0] n, input logic [7:0] p,
                                         input logic f, input logic e);
    regRead = 8'h00;
    case (off)
      pmt_pkg::OFF_CTRL: regRead = c & pmt_pkg::CTRL_WMASK;
      pmt_pkg::OFF_COUNT: regRead = n;
      pmt_pkg::OFF_PERIOD: regRead = p;
      pmt_pkg::OFF_STATUS: regRead = {7'h00, f};
      pmt_pkg::OFF_ENABLE: regRead = {7'h00, e};
      default: regRead = 8'h00;
    endcase
  endfunction

  // Tells whether a divider counter has reached its last state.
  function automatic logic atLast(input logic [3:0] cur, input logic [3:0] last);
    atLast = (cur >= last);
  endfunction

  // Gives the next state of a divider counter that wraps after its last state.
  function automatic logic [3:0] divNext(input logic [3:0] cur, input logic [3:0] last);
    if (atLast(cur, last)) begin
      divNext = 4'h0;
    end else begin
      divNext = cur + 4'h1;
    end
  endfunction

  // Maps the prescale select field to the last state of the prescaler.
  function automatic logic [3:0] preDecode(input logic [1:0] sel);
    case (sel)
      2'b00: preDecode = pmt_pkg::PRE_DIV1;
      2'b01: preDecode = pmt_pkg::PRE_DIV4;
      default: preDecode = pmt_pkg::PRE_DIV16;
    endcase
  endfunction

  // Tells whether the address phase of a transfer is on the bus.
  function automatic logic isAddrPhase(input logic sel, input logic rdy, input logic [1:0] trans);
    isAddrPhase = sel && rdy && (trans == pmt_pkg::HTRANS_NONSEQ);
  endfunction

  // Bus: address phase captured, zero wait state data phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addrPhase = isAddrPhase(hsel, hready, htrans);
  assign rdPhase = addrPhase && !hwrite;

  // Read data of the addressed register, taken in the address phase.
  always_comb begin
    readByte = regRead(haddr[7:0], ctrl_ff, count_ff, period_ff, flag_ff, enable_ff);
  end

  always_comb begin
    nxt_req.valid = addrPhase;
    nxt_req.write = hwrite;
    nxt_req.addr = haddr[7:0];
    nxt_hrdata = hrdata_ff;
    if (rdPhase) begin
      nxt_hrdata = {24'h000000, readByte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_ff <= '0;
      hrdata_ff <= 32'h00000000;
    end else begin
      req_ff <= nxt_req;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Write strobes of the data phase.
  always_comb begin
    wrEn = req_ff.valid && req_ff.write;
    wrCtrl = wrEn && (req_ff.addr == pmt_pkg::OFF_CTRL);
    wrCount = wrEn && (req_ff.addr == pmt_pkg::OFF_COUNT);
    wrPeriod = wrEn && (req_ff.addr == pmt_pkg::OFF_PERIOD);
    wrEnable = wrEn && (req_ff.addr == pmt_pkg::OFF_ENABLE);
    wrClear = wrEn && (req_ff.addr == pmt_pkg::OFF_CLEAR);
    clearReq = wrClear && hwdata[0];
    scalerClear = wrCtrl || wrCount;
  end

  // Instruction clock enable, one pulse per four system clocks.
  always_comb begin
    nxt_instr = instr_ff + 2'h1;
    instrTick = (instr_ff == pmt_pkg::INSTR_LAST);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      instr_ff <= 2'h0;
    end else begin
      instr_ff <= nxt_instr;
    end
  end

  // Prescaler, advanced by instruction ticks while running.
  always_comb begin
    runOn = ctrl_ff[pmt_pkg::RUN_BIT];
    preSel = ctrl_ff[pmt_pkg::PS_LO+1 -: 2];
    preLast = preDecode(preSel);
    nxt_pre = pre_ff;
    preTick = 1'b0;
    if (runOn && instrTick) begin
      preTick = atLast(pre_ff, preLast);
      nxt_pre = divNext(pre_ff, preLast);
    end
    if (scalerClear) begin
      nxt_pre = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // Count register, back to zero on the increment after a period match.
  always_comb begin
    matchHit = preTick && (count_ff == period_ff);
    nxt_count = count_ff;
    if (preTick) begin
      if (matchHit) begin
        nxt_count = pmt_pkg::COUNT_RESET;
      end else begin
        nxt_count = count_ff + 8'h01;
      end
    end
    if (wrCtrl) begin
      nxt_count = count_ff;
    end
    if (wrCount) begin
      nxt_count = hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_ff <= pmt_pkg::COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Postscaler, advanced by each period match.
  always_comb begin
    postLast = ctrl_ff[pmt_pkg::POST_LO+3 -: 4];
    nxt_post = post_ff;
    postTick = 1'b0;
    if (matchHit) begin
      postTick = atLast(post_ff, postLast);
      nxt_post = divNext(post_ff, postLast);
    end
    if (scalerClear) begin
      nxt_post = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      post_ff <= 4'h0;
    end else begin
      post_ff <= nxt_post;
    end
  end

  // Control register.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrCtrl) begin
      nxt_ctrl = hwdata[7:0] & pmt_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_ff <= pmt_pkg::CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Period register.
  always_comb begin
    nxt_period = period_ff;
    if (wrPeriod) begin
      nxt_period = hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      period_ff <= pmt_pkg::PERIOD_RESET;
    end else begin
      period_ff <= nxt_period;
    end
  end

  // Interrupt enable register.
  always_comb begin
    nxt_enable = enable_ff;
    if (wrEnable) begin
      nxt_enable = hwdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_ff <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // Match event flag; a set in the same cycle as a clear wins.
  always_comb begin
    nxt_flag = flag_ff;
    if (clearReq) begin
      nxt_flag = 1'b0;
    end
    if (postTick) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // Level interrupt request.
  assign irq = flag_ff && enable_ff;
endmodule

// ---- src/pmt_pkg.sv ----
// Package with register map, field layout and constants of the period match timer.
package pmt_pkg;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7f;
  localparam int PS_LO = 0;
  localparam int RUN_BIT = 2;
  localparam int POST_LO = 3;
  localparam logic [3:0] PRE_DIV1 = 4'h0;
  localparam logic [3:0] PRE_DIV4 = 4'h3;
  localparam logic [3:0] PRE_DIV16 = 4'hf;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_ENABLE = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } pmt_req_s;
endpackage

// ---- testbench/pmt_checker.sv ----
// Checker of bus and interrupt behaviour of the period match timer.
`timescale 1ns/1ps
module pmt_checker (
  // Watched ports.
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic rd, wr;
  assign rd = hsel && htrans == 2'h2 && !hwrite;
  assign wr = hsel && htrans == 2'h2 && hwrite;
  no_wait_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  reset_quiet_a: assert property ($fell(srst) |-> !irq && hrdata == 32'h0) else $error("not idle");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  ctrl_top_a: assert property (rd && haddr[7:0] == 8'h00 |=> !hrdata[7]) else $error("control bit 7 set");
  unmapped_zero_a: assert property (rd && haddr[7:0] == 8'h18 |=> hrdata == 32'h0) else $error("unmapped");
  flag_shown_a: assert property (rd && haddr[7:0] == 8'h0c && irq |=> hrdata[0]) else $error("flag hidden");
  event_bits_a: assert property (rd && haddr[7:0] >= 8'h0c |=> hrdata[7:1] == 7'h0) else $error("bits set");
  mask_off_a: assert property (wr && haddr[7:0] == 8'h10 ##1 !hwdata[0] |=> !irq) else $error("irq masked");
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench of the period match timer.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0, rdPh = 1'b0, irq, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q[$];
  logic [7:0] v;
  int mismatches = 0, nTests = 0, cyc = 0, n, t, i;
  always #5 clk_sys = ~clk_sys;
  pmt_period_match_timer8 u_dut (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq);
  task chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    $display("tests %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, d, e);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdPh <= !w;
    if (!w) q.push_back({24'h0, e});
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdPh <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (rdPh && hreadyout) chk(hrdata, q.pop_front());
    if (cyc > 20000) begin
      mismatches++;
      results;
    end
  end
  initial begin
    v = 8'($urandom(32'h46835c8d));
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    bus(0, 8'h00, 8'h0, 8'h00);
    bus(0, 8'h08, 8'h0, 8'hff);
    bus(0, 8'h18, 8'h0, 8'h00);
    bus(1, 8'h00, 8'hff, 8'h0);
    bus(0, 8'h00, 8'h0, 8'h7f);
    bus(1, 8'h04, v, 8'h0);
    bus(1, 8'h08, ~v, 8'h0);
    bus(1, 8'h00, 8'h7b, 8'h0);
    repeat (99) @(posedge clk_sys);
    bus(0, 8'h04, 8'h0, v);
    bus(0, 8'h08, 8'h0, ~v);
    for (i = 0; i < 4; i++) begin
      t = (5 * i + 1) * 16 * (i == 0 ? 1 : i == 1 ? 4 : 16);
      bus(1, 8'h08, 8'h03, 8'h0);
      bus(1, 8'h04, 8'h00, 8'h0);
      bus(1, 8'h10, 8'h01, 8'h0);
      bus(1, 8'h00, {1'b0, 4'(5 * i), 1'b1, 2'(i)}, 8'h0);
      n = 0;
      while (irq !== 1'b1 && n < t + 12) begin
        @(posedge clk_sys);
        n++;
      end
      chk(32'(n + 7 > t && n < t + 7), 32'h1);
      bus(1, 8'h00, 8'h00, 8'h0);
      bus(0, 8'h0c, 8'h0, 8'h01);
      bus(1, 8'h10, 8'h00, 8'h0);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      bus(1, 8'h14, 8'h01, 8'h0);
      bus(0, 8'h0c, 8'h0, 8'h00);
    end
    results;
  end
endmodule
bind pmt_period_match_timer8 pmt_checker u_chk (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hreadyout, .hresp, .hrdata, .irq);
